// [src/relay_port_pkg.sv]
/*
 * constants of the eight-channel relay output byte port: image offsets,
 * widths, reset values and the status-bar blink timing.
 * assumes a 125 MHz core clock; nothing else is shared between files.
 */
package relay_port_pkg;

	// channel count and image layout
	localparam int CHANNELS = 8;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_RELAY_IMAGE = 4'h0;
	localparam logic [CHANNELS-1:0] RELAY_RESET = 8'h00;
	localparam logic [CHANNELS-1:0] INPUT_IMAGE_EMPTY = 8'h00;
	localparam logic [7:0] INPUT_IMAGE_BYTES = 8'h00;

	// fault sense lines gathered by the synchroniser
	localparam int FAULT_W = 3;
	localparam int FAULT_OVERLOAD = 0;
	localparam int FAULT_SHORT = 1;
	localparam int FAULT_OVERHEAT = 2;

	// status-bar blink: 1 Hz, half a period on and half off
	localparam int CLK_PERIOD_NS = 8;
	localparam int BLINK_PERIOD_NS = 1_000_000_000;
	localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

endpackage : relay_port_pkg

// [src/pin_sync.sv]
/*
 * two-stage synchroniser bank for asynchronous pin inputs.
 * assumes the pins change no faster than a few clock cycles.
 */
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s state;
	sync_s next_state;

	// first stage is read only by the second
	always_comb begin
		next_state.meta = pin;
		next_state.stable = state.meta;
	end

	// register both stages
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level = state.stable;

endmodule : pin_sync

// [src/relay_output_byte_port.sv]
/*
 * eight-channel relay output byte port: takes the output image byte from
 * the backplane logic, drives the relays and channel indicators, and runs
 * the green and red status-bar indicators with a 1 Hz blink.
 * assumes the backplane logic shares core_clk and hands over a one-cycle
 * write strobe; relay fault sense lines are asynchronous pins.
 */
`timescale 1ns/1ps

module relay_output_byte_port #(
	parameter int BLINK_HALF = relay_port_pkg::BLINK_HALF_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic image_wr,
	input wire logic [relay_port_pkg::ADDR_W-1:0] image_addr,
	input wire logic [relay_port_pkg::CHANNELS-1:0] image_data,
	input wire logic input_rd,
	input wire logic bus_comm_fail,
	input wire logic config_error,
	input wire logic overload_pin,
	input wire logic short_pin,
	input wire logic overheat_pin,
	output logic [relay_port_pkg::CHANNELS-1:0] relay,
	output logic [relay_port_pkg::CHANNELS-1:0] channel_led,
	output logic status_green,
	output logic status_red,
	output logic [relay_port_pkg::CHANNELS-1:0] input_rd_data,
	output logic input_rd_empty,
	output logic [7:0] input_image_size
);

	localparam int CW = (BLINK_HALF > 1) ? $clog2(BLINK_HALF) : 1;
	localparam logic [CW-1:0] BLINK_LAST = CW'(BLINK_HALF - 1);

	typedef struct packed {
		logic [relay_port_pkg::CHANNELS-1:0] relay;
		logic [relay_port_pkg::CHANNELS-1:0] led;
		logic armed;
		logic green;
		logic red;
		logic [CW-1:0] blink_cnt;
		logic blink_phase;
		logic rd_empty;
		logic [relay_port_pkg::CHANNELS-1:0] rd_data;
		logic [7:0] image_size;
	} port_s;

	port_s state;
	port_s next_state;
	logic [relay_port_pkg::FAULT_W-1:0] fault_level;
	logic module_fault;
	logic image_hit;

	// fault sense pins cross into the core clock
	pin_sync #(
		.WIDTH(relay_port_pkg::FAULT_W)
	) fault_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin({overheat_pin, short_pin, overload_pin}),
		.level(fault_level)
	);

	// any of the three sensed faults counts as a module error
	assign module_fault = |fault_level;

	// only a write to the image offset is taken, others are ignored
	assign image_hit = image_wr && (image_addr == relay_port_pkg::OFF_RELAY_IMAGE);

	// next state of the whole port
	always_comb begin
		next_state = state;

		// take the output byte; bit n steers channel n
		if (image_hit) begin
			next_state.relay = image_data;
			next_state.led = image_data;
			next_state.armed = 1'b1;
		end

		// free-running half-period counter for the 1 Hz blink
		if (state.blink_cnt == BLINK_LAST) begin
			next_state.blink_cnt = '0;
			next_state.blink_phase = ~state.blink_phase;
		end else begin
			next_state.blink_cnt = state.blink_cnt + CW'(1);
		end

		// green: blink on bus failure, steady when all good, else off
		if (bus_comm_fail) begin
			next_state.green = state.blink_phase;
		end else if (!module_fault && !config_error) begin
			next_state.green = 1'b1;
		end else begin
			next_state.green = 1'b0;
		end

		// red: sensed fault wins over a configuration error
		if (module_fault) begin
			next_state.red = 1'b1;
		end else if (config_error) begin
			next_state.red = state.blink_phase;
		end else begin
			next_state.red = 1'b0;
		end

		// reads of the input image find nothing mapped
		next_state.rd_empty = input_rd;
		// no input bytes are mapped, so data and size stay empty
		next_state.rd_data = relay_port_pkg::INPUT_IMAGE_EMPTY;
		next_state.image_size = relay_port_pkg::INPUT_IMAGE_BYTES;
	end

	// register the whole state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0; // relays dark after reset
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flops
	assign relay = state.relay;
	assign channel_led = state.led;
	assign status_green = state.green;
	assign status_red = state.red;
	assign input_rd_empty = state.rd_empty;
	// the module maps no input bytes, so these flops hold empty values
	assign input_rd_data = state.rd_data;
	assign input_image_size = state.image_size;

	// checks on the port's outputs and its blink state
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// single-cycle conditions: image write, stray write and blink wrap
	sequence s_image_write;
		image_wr && (image_addr == relay_port_pkg::OFF_RELAY_IMAGE);
	endsequence

	sequence s_stray_write;
		image_wr && (image_addr != relay_port_pkg::OFF_RELAY_IMAGE);
	endsequence

	sequence s_blink_wrap;
		state.blink_cnt == BLINK_LAST;
	endsequence

	// relay byte follows the written byte one edge later
	a_image_to_relay:
	assert property (s_image_write |=> relay == $past(image_data))
		else $error("relay byte does not follow image write");

	// writes elsewhere leave the relays alone
	a_stray_write_ignored:
	assert property (s_stray_write and !image_hit |=> $stable(relay))
		else $error("relay changed on unmapped write");

	// input reads answer empty one edge later with zero data
	a_input_image_empty:
	assert property (input_rd |=> input_rd_empty && input_rd_data == '0
		&& input_image_size == '0)
		else $error("input image returned data");

	// green steady while all is well
	a_green_steady:
	assert property (!bus_comm_fail && !module_fault && !config_error |=> status_green)
		else $error("green not lit while bus and module good");

	// red steady on a sensed fault
	a_red_fault:
	assert property (module_fault |=> status_red)
		else $error("red not lit on module fault");

	// red blink tracks the blink phase on a configuration error
	a_red_config_blink:
	assert property (config_error && !module_fault |=> status_red == $past(state.blink_phase))
		else $error("red does not blink on configuration error");

	// green blink tracks the blink phase on bus failure
	a_green_bus_blink:
	assert property (bus_comm_fail |=> status_green == $past(state.blink_phase))
		else $error("green does not blink on bus failure");

	// blink phase flips exactly at the half-period wrap
	a_blink_half_period:
	assert property ((s_blink_wrap |=> state.blink_phase != $past(state.blink_phase))
		and (state.blink_cnt != BLINK_LAST
		|=> $stable(state.blink_phase)))
		else $error("blink phase flipped off the half period");

	// channel indicators mirror the relays
	a_channel_led:
	assert property (s_image_write |=> channel_led == $past(image_data) && channel_led == relay)
		else $error("channel indicator does not match relay");

	// nothing driven before the first valid byte
	a_dark_until_armed:
	assert property (!state.armed |-> relay == '0 && channel_led == '0)
		else $error("relay driven before first byte");

	// the empty answer stands one cycle only
	a_empty_one_cycle:
	assert property (!input_rd |=> !input_rd_empty)
		else $error("input read answer stuck");

	// red dark with no fault and no configuration error
	a_red_clear:
	assert property (!module_fault && !config_error |=> !status_red)
		else $error("red lit without an error");

	// green dark on an error while the bus is fine
	a_green_error_off:
	assert property (!bus_comm_fail && (module_fault || config_error) |=> !status_green)
		else $error("green lit during an error");

	// relays and indicators hold between accepted writes
	a_relay_hold:
	assert property (!image_hit |=> $stable(relay) && $stable(channel_led))
		else $error("relay changed without a write");

endmodule : relay_output_byte_port

// [verif/bus_master_model.sv]
/*
 * backplane bus master model: output image writes and input image reads.
 * assumes the port shares core_clk; signals change 1 ns after an edge.
 */
`timescale 1ns/1ps

module bus_master_model (
	input wire logic core_clk,
	output logic image_wr,
	output logic [3:0] image_addr,
	output logic [7:0] image_data,
	output logic input_rd
);
	// idle bus from time zero
	initial begin
		image_wr = 1'b0;
		image_addr = 4'h0;
		image_data = 8'h00;
		input_rd = 1'b0;
	end

	// one write strobe, data scrambled once released
	// a real master spaces toggles of one channel far apart
	task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		image_wr = 1'b1;
		image_addr = a;
		image_data = d;
		@(posedge core_clk) #1;
		image_wr = 1'b0;
		image_data = ~d;
	endtask : write_byte

	// one input read strobe
	task automatic read_input();
		@(posedge core_clk) #1;
		input_rd = 1'b1;
		@(posedge core_clk) #1;
		input_rd = 1'b0;
	endtask : read_input
endmodule : bus_master_model

// [verif/testbench.sv]
/*
 * self-checking bench of the relay output byte port.
 * assumes a blink half period shortened to 4 cycles.
 */
`timescale 1ns/1ps

module testbench;
	localparam int HALF = 4;
	logic core_clk, rst_n, bus_comm_fail, config_error;
	logic [2:0] fault_pins;
	logic image_wr, input_rd, status_green, status_red, input_rd_empty;
	logic [3:0] image_addr;
	logic [7:0] image_data, relay, channel_led, input_rd_data, input_image_size;
	int n_fail = 0;
	int num_checks = 0;

	// bus master and port
	bus_master_model bus_master_model_i (.core_clk(core_clk), .image_wr(image_wr),
		.image_addr(image_addr), .image_data(image_data), .input_rd(input_rd));
	relay_output_byte_port #(.BLINK_HALF(HALF)) relay_output_byte_port_i (
		.core_clk(core_clk), .rst_n(rst_n), .image_wr(image_wr),
		.image_addr(image_addr), .image_data(image_data), .input_rd(input_rd),
		.bus_comm_fail(bus_comm_fail), .config_error(config_error),
		.overload_pin(fault_pins[0]), .short_pin(fault_pins[1]),
		.overheat_pin(fault_pins[2]), .relay(relay), .channel_led(channel_led),
		.status_green(status_green), .status_red(status_red),
		.input_rd_data(input_rd_data), .input_rd_empty(input_rd_empty),
		.input_image_size(input_image_size));

	// count and report one comparison
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	// counts and verdict
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// dark after reset, then steady green
	task automatic t_reset();
		check(relay === 8'h00 && channel_led === 8'h00, "not dark");
		repeat (3) @(posedge core_clk);
		#1;
		check(status_green === 1'b1 && status_red === 1'b0, "green off");
	endtask : t_reset

	// walking one, unmapped write, clear
	task automatic t_write();
		for (int n = 0; n < 8; n++) begin
			bus_master_model_i.write_byte(4'h0, 8'h01 << n);
			check(relay === 8'h01 << n && channel_led === relay, "bit lost");
		end
		bus_master_model_i.write_byte(4'h1, 8'h5a);
		check(relay === 8'h80, "unmapped write");
		bus_master_model_i.write_byte(4'h0, 8'h00);
		check(channel_led === 8'h00, "led lit");
	endtask : t_write

	// input read returns nothing
	task automatic t_read();
		bus_master_model_i.read_input();
		check(input_rd_empty === 1'b1 && input_rd_data === 8'h00, "input data");
		check(input_image_size === 8'h00, "input size");
		@(posedge core_clk);
		#1;
		check(input_rd_empty === 1'b0, "empty stuck");
	endtask : t_read

	// mid-run reset darkens the relays until the next byte
	task automatic t_rearm();
		bus_master_model_i.write_byte(4'h0, 8'ha5);
		check(relay === 8'ha5 && channel_led === 8'ha5, "byte lost");
		rst_n = 1'b0;
		#1;
		check(relay === 8'h00 && channel_led === 8'h00, "lit in reset");
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		check(relay === 8'h00 && channel_led === 8'h00, "lit after reset");
		check(status_green === 1'b1, "green after reset");
		bus_master_model_i.write_byte(4'h0, 8'h3c);
		check(relay === 8'h3c && channel_led === 8'h3c, "rearm lost");
	endtask : t_rearm

	// each fault pin lights red steadily
	task automatic t_fault();
		for (int k = 0; k < 3; k++) begin
			fault_pins[k] = 1'b1;
			repeat (3) @(posedge core_clk);
			#1;
			check(status_red === 1'b1 && status_green === 1'b0, "red off");
			fault_pins[k] = 1'b0;
			repeat (3) @(posedge core_clk);
			#1;
			check(status_red === 1'b0 && status_green === 1'b1, "red stuck");
		end
	endtask : t_fault

	// toggles of one status light over sixteen cycles
	task automatic toggles(input logic grn, output int t);
		logic prev;
		t = 0;
		repeat (2) @(posedge core_clk);
		#1;
		prev = grn ? status_green : status_red;
		repeat (4 * HALF) begin
			@(posedge core_clk);
			#1;
			if ((grn ? status_green : status_red) !== prev) t++;
			prev = grn ? status_green : status_red;
		end
	endtask : toggles

	// configuration error blinks red, bus failure blinks green
	task automatic t_blink();
		int t;
		config_error = 1'b1;
		toggles(1'b0, t);
		check(t == 4 && status_green === 1'b0, "red steady");
		config_error = 1'b0;
		bus_comm_fail = 1'b1;
		toggles(1'b1, t);
		check(t == 4 && status_red === 1'b0, "green steady");
		bus_comm_fail = 1'b0;
	endtask : t_blink

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// hang guard
	initial begin
		#20000;
		n_fail++;
		end_sim();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		bus_comm_fail = 1'b0;
		config_error = 1'b0;
		fault_pins = 3'h0;
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_rearm();
		t_read();
		t_fault();
		t_blink();
		end_sim();
	end
endmodule : testbench
